// [design/pw_pkg.sv]
package pw_pkg;

	// header geometry, in bytes
	localparam int CW_BYTES   = 4;
	localparam int RTP_BYTES  = 12;
	localparam int HDR_RTP    = CW_BYTES + RTP_BYTES;
	localparam int LEN_LIMIT  = 64;

	// payload sizes every build must carry
	localparam int PAY_E1     = 256;
	localparam int PAY_T1     = 192;
	localparam int PAY_E3T3   = 1024;
	localparam int PAY_T1_OCT = 200;

	// octet-aligned T1 subframe: 193 line bits then 7 pad bits
	localparam int SUB_BYTES     = 25;
	localparam int T1_SUB_BITS   = 193;
	localparam int T1_PAD_BITS   = 7;
	localparam logic [7:0] SUB_LAST = 8'(T1_SUB_BITS - 1);
	localparam logic [2:0] PAD_INIT = 3'(T1_PAD_BITS);

	// control word bit positions, counted from the msb as bit 0
	localparam int CW_L_POS   = 4;
	localparam int CW_R_POS   = 5;

	// fixed rtp header: version 2, no padding, extension or csrc
	localparam logic [7:0] RTP_B0    = 8'h80;
	localparam logic [7:0] FILL_BYTE = 8'hff;

	localparam logic [15:0] SEQ_RST = 16'h0000;
	localparam logic [31:0] TS_RST  = 32'h0000_0000;

	typedef struct packed {
		logic [3:0]  first_nib; // zero except for an associated channel header
		logic        lflag;     // attachment circuit fault
		logic        rflag;     // local receive side in packet loss
		logic [3:0]  rsv_frg;   // reserved and fragmentation
		logic [5:0]  len;       // short packet length, else zero
		logic [15:0] seq;
	} cw_t;

	typedef struct packed {
		logic [10:0] pay_size;  // payload bytes per packet, same both ways
		logic        rtp_en;    // fixed rtp header present
		logic        udp_mode;  // rtp header precedes the control word
		logic        oct_t1;    // octet-aligned T1 padding
		logic        omit_on_l; // drop payload while the L flag is set
		logic        len_en;    // fill LEN for short packets
		logic        ts_diff;   // differential timestamps from common tick
		logic [6:0]  pt;        // dynamic payload type, both directions
		logic [31:0] ssrc;      // transmitted and expected source
		logic [31:0] ts_step;   // absolute-mode increment per packet
	} cfg_t;

endpackage : pw_pkg

// [design/pw_fifo.sv]
`timescale 1ns/1ps
module pw_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             core_clk_i, // core clock
	input  wire logic             rst_i,      // synchronous reset
	input  wire logic             ce_i,       // clock enable
	input  wire logic [WIDTH-1:0] in_data_i,  // write data
	input  wire logic             in_valid_i, // write request
	output logic                  in_ready_o, // room for a word
	output logic      [WIDTH-1:0] out_data_o, // head word
	output logic                  out_valid_o,// head word present
	input  wire logic             out_ready_i // head word taken
);
	localparam int AW = $clog2(DEPTH);

	generate
		if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
			$error("pw_fifo depth must be a power of two, at least 2");
		end
	endgenerate

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_ff;
	logic [AW-1:0]    rd_ptr_ff;
	logic [AW:0]      count_ff;
	logic             wr;
	logic             rd;

	assign in_ready_o  = (count_ff != (AW+1)'(DEPTH));
	assign out_valid_o = (count_ff != '0);
	assign out_data_o  = mem[rd_ptr_ff];
	assign wr          = ce_i & in_valid_i & in_ready_o;
	assign rd          = ce_i & out_valid_o & out_ready_i;

	always_ff @(posedge core_clk_i) begin
		if (wr) begin
			mem[wr_ptr_ff] <= in_data_i;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff  <= '0;
		end else begin
			if (wr) begin
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			end
			if (rd) begin
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
			end
			count_ff <= count_ff + (AW+1)'(wr) - (AW+1)'(rd);
		end
	end

endmodule : pw_fifo

// [design/pw_packetizer.sv]
`timescale 1ns/1ps
// Functional notes
// - first control word nibble sent zero; nonzero flagged
// - L flag follows attachment circuit fault
// - L packets may omit payload; receiver plays filler
// - R flag follows local packet loss state
// - reserved/fragment bits sent zero, ignored on receive
// - LEN holds short length, zero from 64
// - LEN zero: check size against configured payload
// - 16-bit wrapping sequence, seeded, plus one per packet
// - rtp padding, extension, csrc count, marker zero
// - configured payload type sent; mismatch is malformed
// - rtp sequence equals control word sequence
// - timestamp tick is 8 kHz multiple
// - absolute timestamps follow line-derived payload count
// - differential timestamps count shared reference tick
// - received source compared to expected for misconnection
// - one fixed payload size, both directions
// - line bits fill bytes msb first, line order
// - payload sizes 256, 192, 1024 supported
// - no byte or frame alignment assumed
// - octet T1: 193 line bits plus 7 pad bits
// - octet T1 200-byte payload supported
// - control word always; rtp before it in udp mode
// - sequence read from bytes 2-3 of first word; in udp mode with rtp the high byte is the previous control word's last byte
// - all-ones filler for lost and invalid payload
module pw_packetizer #(
	parameter int FIFO_DEPTH = 8,
	parameter int MAX_PAY    = pw_pkg::PAY_E3T3
) (
	input  wire logic         core_clk_i,     // 20 MHz core clock
	input  wire logic         rst_i,          // synchronous reset, active high
	input  wire logic         ce_i,           // clock enable, freezes all state
	input  wire pw_pkg::cfg_t cfg_i,          // pseudowire configuration
	input  wire logic [15:0]  seq_seed_i,     // unpredictable initial sequence
	input  wire logic         tx_en_i,        // packetizing enabled
	input  wire logic         ac_fault_i,     // attachment circuit fault
	input  wire logic         loss_state_i,   // local receive side in packet loss
	input  wire logic         line_bit_i,     // line data pin
	input  wire logic         line_strobe_i,  // line bit clock pin
	input  wire logic         ts_tick_i,      // common reference tick pin
	output logic [7:0]        tx_data_o,      // packet byte out
	output logic              tx_valid_o,     // packet byte valid
	output logic              tx_sop_o,       // first byte of packet
	output logic              tx_eop_o,       // last byte of packet
	input  wire logic         tx_ready_i,     // packet sink accepts
	output logic              tx_ovf_o,       // sticky line overrun
	input  wire logic [7:0]   rx_data_i,      // received packet byte
	input  wire logic         rx_valid_i,     // received byte valid
	input  wire logic         rx_sop_i,       // first received byte
	input  wire logic         rx_eop_i,       // last received byte
	output logic              rx_ready_o,     // receive side accepts
	input  wire logic         fill_req_i,     // one lost packet to replace
	output logic [7:0]        pay_data_o,     // payload toward jitter buffer
	output logic              pay_valid_o,    // payload byte valid
	output logic              rx_done_o,      // packet end pulse
	output logic              rx_malformed_o, // packet malformed pulse
	output logic              rx_stray_o,     // source mismatch pulse
	output logic              rx_ach_o,       // channel header packet pulse
	output logic [15:0]       rx_seq_o,       // last received sequence
	output logic              rx_lflag_o,     // last received L flag
	output logic              rx_rflag_o      // remote packet loss
);
	generate
		if (FIFO_DEPTH < 2 || MAX_PAY < pw_pkg::PAY_E3T3 || MAX_PAY > 2047) begin : g_bad
			$error("pw_packetizer parameters out of range");
		end
	endgenerate

	typedef enum logic [3:0] {
		TX_IDLE = 4'b0001,
		TX_HDR  = 4'b0010,
		TX_PAY  = 4'b0100,
		TX_SKIP = 4'b1000
	} tx_state_t;

	// ---------------- pin synchronisers ----------------
	logic [1:0] bit_sync_ff;
	logic [1:0] stb_sync_ff;
	logic [1:0] tick_sync_ff;
	logic       stb_last_ff;
	logic       tick_last_ff;
	logic       stb_rise;
	logic       tick_rise;

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			bit_sync_ff  <= '0;
			stb_sync_ff  <= '0;
			tick_sync_ff <= '0;
			stb_last_ff  <= 1'b0;
			tick_last_ff <= 1'b0;
		end else if (ce_i) begin
			bit_sync_ff  <= {bit_sync_ff[0], line_bit_i};
			stb_sync_ff  <= {stb_sync_ff[0], line_strobe_i};
			tick_sync_ff <= {tick_sync_ff[0], ts_tick_i};
			stb_last_ff  <= stb_sync_ff[1];
			tick_last_ff <= tick_sync_ff[1];
		end
	end

	assign stb_rise  = stb_sync_ff[1] & ~stb_last_ff;
	assign tick_rise = tick_sync_ff[1] & ~tick_last_ff;

	// ---------------- bit to byte assembly ----------------
	// bytes start wherever the stream starts; no framing is searched for
	logic [7:0] asm_sr_ff;
	logic [2:0] asm_cnt_ff;
	logic [7:0] sub_cnt_ff;
	logic [2:0] pad_left_ff;
	logic [7:0] asm_byte_ff;
	logic       asm_push_ff;
	logic       ovf_ff;
	logic       shift_en;
	logic       shift_bit;
	logic       fifo_in_rdy;
	logic [7:0] fifo_out_data;
	logic       fifo_out_valid;
	logic       fifo_out_rdy;

	// pad bits take 7 cycles; the line strobe must be slower than that
	assign shift_en  = stb_rise | (pad_left_ff != '0);
	assign shift_bit = (pad_left_ff != '0) ? 1'b0 : bit_sync_ff[1];

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			asm_sr_ff   <= '0;
			asm_cnt_ff  <= '0;
			sub_cnt_ff  <= '0;
			pad_left_ff <= '0;
			asm_byte_ff <= '0;
			asm_push_ff <= 1'b0;
			ovf_ff      <= 1'b0;
		end else if (ce_i) begin
			if (asm_push_ff && fifo_in_rdy) begin
				asm_push_ff <= 1'b0;
			end
			if (shift_en) begin
				asm_sr_ff  <= {asm_sr_ff[6:0], shift_bit};
				asm_cnt_ff <= asm_cnt_ff + 3'h1;
				if (asm_cnt_ff == 3'h7) begin
					asm_byte_ff <= {asm_sr_ff[6:0], shift_bit};
					asm_push_ff <= 1'b1;
					// line cannot stall, so a still-pending byte is lost
					if (asm_push_ff && !fifo_in_rdy) begin
						ovf_ff <= 1'b1;
					end
				end
			end
			if (pad_left_ff != '0) begin
				pad_left_ff <= pad_left_ff - 3'h1;
			end else if (stb_rise && cfg_i.oct_t1) begin
				if (sub_cnt_ff == pw_pkg::SUB_LAST) begin
					sub_cnt_ff  <= '0;
					pad_left_ff <= pw_pkg::PAD_INIT;
				end else begin
					sub_cnt_ff <= sub_cnt_ff + 8'h01;
				end
			end
		end
	end

	pw_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_tx_fifo (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.ce_i       (ce_i),
		.in_data_i  (asm_byte_ff),
		.in_valid_i (asm_push_ff),
		.in_ready_o (fifo_in_rdy),
		.out_data_o (fifo_out_data),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_out_rdy)
	);

	// ---------------- header byte selection ----------------
	function automatic logic [7:0] cw_byte(input pw_pkg::cw_t w, input logic [1:0] k);
		logic [31:0] v;
		v = w;
		case (k)
			2'h0:    cw_byte = v[31:24];
			2'h1:    cw_byte = v[23:16];
			2'h2:    cw_byte = v[15:8];
			default: cw_byte = v[7:0];
		endcase
	endfunction : cw_byte

	function automatic logic [7:0] rtp_byte(input pw_pkg::cfg_t c, input logic [15:0] sq,
		input logic [31:0] ts, input logic [3:0] j);
		case (j)
			4'h0:    rtp_byte = pw_pkg::RTP_B0;
			4'h1:    rtp_byte = {1'b0, c.pt};
			4'h2:    rtp_byte = sq[15:8];
			4'h3:    rtp_byte = sq[7:0];
			4'h4:    rtp_byte = ts[31:24];
			4'h5:    rtp_byte = ts[23:16];
			4'h6:    rtp_byte = ts[15:8];
			4'h7:    rtp_byte = ts[7:0];
			4'h8:    rtp_byte = c.ssrc[31:24];
			4'h9:    rtp_byte = c.ssrc[23:16];
			4'ha:    rtp_byte = c.ssrc[15:8];
			default: rtp_byte = c.ssrc[7:0];
		endcase
	endfunction : rtp_byte

	logic [4:0]  hdr_len;
	logic [4:0]  cw_off;
	logic [4:0]  rtp_off;
	assign hdr_len = cfg_i.rtp_en ? 5'(pw_pkg::HDR_RTP) : 5'(pw_pkg::CW_BYTES);
	assign cw_off  = (cfg_i.rtp_en && cfg_i.udp_mode) ? 5'(pw_pkg::RTP_BYTES) : 5'h00;
	assign rtp_off = cfg_i.udp_mode ? 5'h00 : 5'(pw_pkg::CW_BYTES);

	// ---------------- transmit packet builder ----------------
	tx_state_t   tx_state_ff;
	pw_pkg::cw_t tx_cw_ff;
	logic [15:0] seq_ff;
	logic [31:0] abs_ts_ff;
	logic [31:0] diff_ts_ff;
	logic [31:0] tx_ts_ff;
	logic [10:0] idx_ff;
	logic        omit_ff;
	logic [7:0]  tx_data_ff;
	logic        tx_valid_ff;
	logic        tx_sop_ff;
	logic        tx_eop_ff;
	logic        out_free;
	logic [11:0] tx_total;
	logic [4:0]  hidx;
	logic [7:0]  hdr_b;
	logic        hdr_last;
	logic        pay_last;

	assign out_free = ~tx_valid_ff | tx_ready_i;
	assign tx_total = 12'(hdr_len) + ((ac_fault_i && cfg_i.omit_on_l) ? 12'h000 : 12'(cfg_i.pay_size));
	assign hidx     = idx_ff[4:0];
	assign hdr_last = (hidx == hdr_len - 5'h01);
	assign pay_last = (idx_ff == cfg_i.pay_size - 11'h001);
	assign fifo_out_rdy = ce_i & (((tx_state_ff == TX_PAY) & out_free) | (tx_state_ff == TX_SKIP));

	always_comb begin
		if (hidx >= cw_off && hidx < cw_off + 5'(pw_pkg::CW_BYTES)) begin
			hdr_b = cw_byte(tx_cw_ff, 2'(hidx - cw_off));
		end else begin
			hdr_b = rtp_byte(cfg_i, tx_cw_ff.seq, tx_ts_ff, 4'(hidx - rtp_off));
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			diff_ts_ff <= pw_pkg::TS_RST;
		end else if (ce_i && tick_rise) begin
			diff_ts_ff <= diff_ts_ff + 32'h1;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			tx_state_ff <= TX_IDLE;
			tx_cw_ff    <= '0;
			seq_ff      <= seq_seed_i;
			abs_ts_ff   <= pw_pkg::TS_RST;
			tx_ts_ff    <= pw_pkg::TS_RST;
			idx_ff      <= '0;
			omit_ff     <= 1'b0;
			tx_data_ff  <= '0;
			tx_valid_ff <= 1'b0;
			tx_sop_ff   <= 1'b0;
			tx_eop_ff   <= 1'b0;
		end else if (ce_i) begin
			if (out_free) begin
				tx_valid_ff <= 1'b0;
			end
			case (tx_state_ff)
				TX_IDLE: begin
					if (tx_en_i) begin
						tx_cw_ff.first_nib <= 4'h0;
						tx_cw_ff.lflag     <= ac_fault_i;
						tx_cw_ff.rflag     <= loss_state_i;
						tx_cw_ff.rsv_frg   <= 4'h0;
						tx_cw_ff.len       <= (cfg_i.len_en && tx_total < 12'(pw_pkg::LEN_LIMIT))
							? 6'(tx_total) : 6'h00;
						tx_cw_ff.seq       <= seq_ff;
						omit_ff            <= ac_fault_i & cfg_i.omit_on_l;
						tx_ts_ff           <= cfg_i.ts_diff ? diff_ts_ff : abs_ts_ff;
						idx_ff             <= '0;
						tx_state_ff        <= TX_HDR;
					end
				end
				TX_HDR: begin
					if (out_free) begin
						tx_data_ff  <= hdr_b;
						tx_valid_ff <= 1'b1;
						tx_sop_ff   <= (hidx == 5'h00);
						tx_eop_ff   <= hdr_last & omit_ff;
						idx_ff      <= hdr_last ? 11'h000 : idx_ff + 11'h001;
						if (hdr_last) begin
							tx_state_ff <= omit_ff ? TX_SKIP : TX_PAY;
						end
					end
				end
				TX_PAY: begin
					if (out_free && fifo_out_valid) begin
						tx_data_ff  <= fifo_out_data;
						tx_valid_ff <= 1'b1;
						tx_sop_ff   <= 1'b0;
						tx_eop_ff   <= pay_last;
						idx_ff      <= idx_ff + 11'h001;
						if (pay_last) begin
							seq_ff      <= seq_ff + 16'h0001;
							abs_ts_ff   <= abs_ts_ff + cfg_i.ts_step;
							tx_state_ff <= TX_IDLE;
						end
					end
				end
				TX_SKIP: begin
					// omitted payload is still drained so the line keeps its time base
					if (fifo_out_valid) begin
						idx_ff <= idx_ff + 11'h001;
						if (pay_last) begin
							seq_ff      <= seq_ff + 16'h0001;
							abs_ts_ff   <= abs_ts_ff + cfg_i.ts_step;
							tx_state_ff <= TX_IDLE;
						end
					end
				end
				default: tx_state_ff <= TX_IDLE;
			endcase
		end
	end

	// ---------------- receive parser ----------------
	logic [11:0] rx_idx_ff;
	logic [31:0] rx_cw_ff;
	logic [6:0]  rx_pt_ff;
	logic [31:0] rx_ssrc_ff;
	logic [12:0] fill_cnt_ff;
	logic [12:0] nxt_fill;
	logic        rx_ready_ff;
	logic        beat;
	logic [11:0] pos;
	logic [11:0] total;
	logic [11:0] exp_full;
	logic        in_cw;
	logic        in_rtp;
	logic [11:0] rtp_j;
	logic [31:0] cw_now;
	logic [6:0]  pt_now;
	logic [31:0] ssrc_now;
	logic        l_now;
	logic        ach_now;
	logic        bad_size;
	logic        bad_pkt;

	assign beat     = ce_i & rx_valid_i & rx_ready_ff;
	assign pos      = rx_sop_i ? 12'h000 : rx_idx_ff;
	assign total    = pos + 12'h001;
	assign exp_full = 12'(hdr_len) + 12'(cfg_i.pay_size);
	assign in_cw    = (pos >= 12'(cw_off)) && (pos < 12'(cw_off) + 12'(pw_pkg::CW_BYTES));
	assign rtp_j    = pos - 12'(rtp_off);
	assign in_rtp   = cfg_i.rtp_en && (pos >= 12'(rtp_off)) && (rtp_j < 12'(pw_pkg::RTP_BYTES));
	assign cw_now   = in_cw ? {rx_cw_ff[23:0], rx_data_i} : rx_cw_ff;
	assign pt_now   = (in_rtp && rtp_j == 12'h001) ? rx_data_i[6:0] : rx_pt_ff;
	assign ssrc_now = (in_rtp && rtp_j >= 12'h008) ? {rx_ssrc_ff[23:0], rx_data_i} : rx_ssrc_ff;
	assign l_now    = cw_now[31 - pw_pkg::CW_L_POS];
	assign ach_now  = (cw_now[31:28] != 4'h0);
	// bits 6 to 9 never enter any check
	assign bad_size = (cw_now[21:16] != 6'h00) ? (total != 12'(cw_now[21:16]))
		: !((total == exp_full) || (l_now && total == 12'(hdr_len)));
	assign bad_pkt  = bad_size | (cfg_i.rtp_en & (pt_now != cfg_i.pt));

	always_comb begin
		nxt_fill = fill_cnt_ff;
		if (fill_cnt_ff != '0 && !beat) begin
			nxt_fill = nxt_fill - 13'h0001;
		end
		if (ce_i && fill_req_i) begin
			nxt_fill = nxt_fill + 13'(cfg_i.pay_size);
		end
		if (beat && rx_eop_i && l_now && !ach_now) begin
			nxt_fill = nxt_fill + 13'(cfg_i.pay_size);
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			rx_idx_ff  <= '0;
			rx_cw_ff   <= '0;
			rx_pt_ff   <= '0;
			rx_ssrc_ff <= '0;
		end else if (beat) begin
			rx_idx_ff  <= total;
			rx_cw_ff   <= cw_now;
			rx_pt_ff   <= pt_now;
			rx_ssrc_ff <= ssrc_now;
		end
	end

	// malformed payload has already been forwarded; the jitter buffer drops it
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			fill_cnt_ff    <= '0;
			rx_ready_ff    <= 1'b0;
			pay_data_o     <= '0;
			pay_valid_o    <= 1'b0;
			rx_done_o      <= 1'b0;
			rx_malformed_o <= 1'b0;
			rx_stray_o     <= 1'b0;
			rx_ach_o       <= 1'b0;
			rx_seq_o       <= '0;
			rx_lflag_o     <= 1'b0;
			rx_rflag_o     <= 1'b0;
		end else if (ce_i) begin
			fill_cnt_ff    <= nxt_fill;
			// a packet end or lost-packet request blocks input until filler is out
			rx_ready_ff    <= (nxt_fill == '0) && !fill_req_i && !(beat && rx_eop_i);
			pay_valid_o    <= 1'b0;
			rx_done_o      <= 1'b0;
			rx_malformed_o <= 1'b0;
			rx_stray_o     <= 1'b0;
			rx_ach_o       <= 1'b0;
			if (beat) begin
				if (pos == 12'h003) begin
					rx_seq_o <= {rx_cw_ff[7:0], rx_data_i};
				end
				if (pos >= 12'(hdr_len) && !l_now && !ach_now) begin
					pay_data_o  <= rx_data_i;
					pay_valid_o <= 1'b1;
				end
				if (rx_eop_i) begin
					rx_done_o      <= 1'b1;
					rx_ach_o       <= ach_now;
					rx_malformed_o <= !ach_now & bad_pkt;
					rx_stray_o     <= cfg_i.rtp_en & (ssrc_now != cfg_i.ssrc);
					rx_lflag_o     <= l_now;
					rx_rflag_o     <= cw_now[31 - pw_pkg::CW_R_POS];
				end
			end else if (fill_cnt_ff != '0) begin
				pay_data_o  <= pw_pkg::FILL_BYTE;
				pay_valid_o <= 1'b1;
			end
		end
	end

	assign tx_data_o  = tx_data_ff;
	assign tx_valid_o = tx_valid_ff;
	assign tx_sop_o   = tx_sop_ff;
	assign tx_eop_o   = tx_eop_ff;
	assign tx_ovf_o   = ovf_ff;
	assign rx_ready_o = rx_ready_ff;

endmodule : pw_packetizer

// [verif/pw_packetizer_checker.sv]
`timescale 1ns/1ps
module pw_packetizer_checker (
	input wire logic         core_clk_i,     // clock
	input wire logic         rst_i,          // reset
	input wire pw_pkg::cfg_t cfg_i,          // config
	input wire logic         ac_fault_i,     // fault
	input wire logic         loss_state_i,   // loss state
	input wire logic [7:0]   tx_data_o,      // tx byte
	input wire logic         tx_valid_o,     // tx valid
	input wire logic         tx_sop_o,       // tx first
	input wire logic         tx_eop_o,       // tx last
	input wire logic         tx_ready_i,     // tx ready
	input wire logic         tx_ovf_o,       // overrun
	input wire logic         rx_valid_i,     // rx valid
	input wire logic         rx_eop_i,       // rx last
	input wire logic         rx_ready_o,     // rx ready
	input wire logic         rx_done_o,      // rx end
	input wire logic         rx_malformed_o  // rx bad
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	// first control word byte, unless the rtp header leads
	sequence s_cw0;
		tx_valid_o && tx_sop_o && !(cfg_i.rtp_en && cfg_i.udp_mode);
	endsequence
	property p_hold;
		tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o) && $stable({tx_sop_o, tx_eop_o});
	endproperty
	a_hold: assert property (p_hold) else $error("tx byte changed while stalled");
	property p_nib;
		s_cw0 |-> tx_data_o[7:4] == 4'h0;
	endproperty
	a_nib: assert property (p_nib) else $error("control word nibble not zero");
	property p_lflag;
		s_cw0 |-> tx_data_o[3] == $past(ac_fault_i, 2);
	endproperty
	a_lflag: assert property (p_lflag) else $error("L flag differs from fault");
	property p_rflag;
		s_cw0 |-> tx_data_o[2] == $past(loss_state_i, 2);
	endproperty
	a_rflag: assert property (p_rflag) else $error("R flag differs from loss state");
	property p_rsv;
		s_cw0 |-> tx_data_o[1:0] == 2'h0;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
	property p_hdr;
		tx_valid_o && tx_sop_o |-> !tx_eop_o;
	endproperty
	a_hdr: assert property (p_hdr) else $error("packet shorter than header");
	property p_rxend;
		rx_valid_i && rx_ready_o && rx_eop_i |=> !rx_ready_o && rx_done_o;
	endproperty
	a_rxend: assert property (p_rxend) else $error("no end pulse after last beat");
	property p_mal;
		rx_malformed_o |-> $past(rx_valid_i && rx_ready_o && rx_eop_i);
	endproperty
	a_mal: assert property (p_mal) else $error("malformed pulse off packet end");
	property p_ovf;
		tx_ovf_o |=> tx_ovf_o;
	endproperty
	a_ovf: assert property (p_ovf) else $error("overrun flag dropped");
	c_lpkt: cover property (s_cw0 ##0 tx_data_o[3]);
	c_mal: cover property (rx_malformed_o);
	c_ovf: cover property (tx_ovf_o);
endmodule : pw_packetizer_checker
bind pw_packetizer pw_packetizer_checker pw_packetizer_checker_inst (.core_clk_i, .rst_i,
	.cfg_i, .ac_fault_i, .loss_state_i, .tx_data_o, .tx_valid_o, .tx_sop_o, .tx_eop_o,
	.tx_ready_i, .tx_ovf_o, .rx_valid_i, .rx_eop_i, .rx_ready_o, .rx_done_o, .rx_malformed_o);

// [verif/pw_peer.sv]
`timescale 1ns/1ps
module pw_peer (
	input  wire logic core_clk_i, // clock
	input  wire logic rst_i,      // reset
	input  wire logic hold_i,     // stall all traffic
	input  wire logic valid_i,    // byte offered
	input  wire logic eop_i,      // last byte offered
	output logic      ready_o,    // byte accepted
	output logic      got_o,      // byte taken this edge
	output logic      got_eop_o   // last byte taken
);
	logic [7:0] lfsr_ff;
	always_ff @(posedge core_clk_i) begin
		if (rst_i) lfsr_ff <= 8'h5a;
		else lfsr_ff <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};
	end
	// the port model stalls at random, and also on request while hold_i is set
	assign ready_o = !hold_i && (lfsr_ff[1:0] != 2'h0);
	assign got_o = valid_i && ready_o;
	assign got_eop_o = got_o && eop_i;
endmodule : pw_peer

// [verif/tdm_pseudowire_packetizer_tb.sv]
`timescale 1ns/1ps
module tdm_pseudowire_packetizer_tb;
	localparam int PS = 8;
	logic core_clk_i, rst_i, tx_en_i, ac_fault_i, loss_state_i, line_bit_i, line_strobe_i;
	logic rx_valid_i, rx_sop_i, rx_eop_i, fill_req_i, hold, skip_tx;
	logic [7:0] rx_data_i;
	logic [15:0] seed;
	pw_pkg::cfg_t cfg;
	wire logic [7:0] tx_data_o, pay_data_o;
	wire logic tx_valid_o, tx_sop_o, tx_eop_o, tx_ovf_o, rx_ready_o, pay_valid_o, tx_ready_i;
	wire logic rx_done_o, rx_malformed_o, rx_ach_o, rx_lflag_o, rx_rflag_o, got, got_eop;
	wire logic [15:0] rx_seq_o;
	logic [7:0] exp_tx[$], exp_pay[$], pk[32];
	logic [31:0] xs_ff, num_errors, n_compared, n_eop, n_end, n_mal, n_ach;
	logic [7:0] tb0[6] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h08, 8'h10};
	logic [7:0] tb1[6] = '{8'hcc, 8'h0c, 8'h00, 8'h00, 8'h0c, 8'h0c};
	int tn[6] = '{12, 11, 12, 13, 12, 12};
	logic [31:0] tm[6] = '{0, 1, 1, 2, 2, 2};
	pw_packetizer pw_packetizer_inst (.core_clk_i, .rst_i, .ce_i(1'b1), .cfg_i(cfg),
		.seq_seed_i(seed), .tx_en_i, .ac_fault_i, .loss_state_i, .line_bit_i, .line_strobe_i,
		.ts_tick_i(1'b0), .tx_data_o, .tx_valid_o, .tx_sop_o, .tx_eop_o, .tx_ready_i, .tx_ovf_o,
		.rx_data_i, .rx_valid_i, .rx_sop_i, .rx_eop_i, .rx_ready_o, .fill_req_i, .pay_data_o,
		.pay_valid_o, .rx_done_o, .rx_malformed_o, .rx_stray_o(), .rx_ach_o, .rx_seq_o,
		.rx_lflag_o, .rx_rflag_o);
	pw_peer pw_peer_inst (.core_clk_i, .rst_i, .hold_i(hold), .valid_i(tx_valid_o),
		.eop_i(tx_eop_o), .ready_o(tx_ready_i), .got_o(got), .got_eop_o(got_eop));
	function automatic logic [31:0] xs();
		xs_ff ^= xs_ff << 13;
		xs_ff ^= xs_ff >> 17;
		xs_ff ^= xs_ff << 5;
		return xs_ff;
	endfunction : xs
	task automatic finish_test();
		if (num_errors == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : finish_test
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic step(input int n);
		repeat (n) @(posedge core_clk_i);
		#2;
	endtask : step
	task automatic wait_cnt(ref logic [31:0] c, input logic [31:0] k);
		for (int i = 0; i < 3000 && c < k; i++) step(1);
		if (c < k) begin
			num_errors++;
			finish_test();
		end
	endtask : wait_cnt
	// strobe spacing of ten cycles stays clear of the synchroniser limit
	task automatic line_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			line_bit_i = b[i];
			line_strobe_i = 1'b1;
			step(5);
			line_strobe_i = 1'b0;
			step(5);
		end
	endtask : line_byte
	task automatic tx_pkt(input logic l, input logic r, input logic [15:0] sq);
		logic [7:0] b;
		logic [31:0] k;
		k = n_eop + 1;
		ac_fault_i = l;
		loss_state_i = r;
		exp_tx.push_back({4'h0, l, r, 2'h0});
		exp_tx.push_back({2'h0, 6'(pw_pkg::CW_BYTES + PS)});
		exp_tx.push_back(sq[15:8]);
		exp_tx.push_back(sq[7:0]);
		tx_en_i = 1'b1;
		step(1);
		tx_en_i = 1'b0;
		for (int i = 0; i < PS; i++) begin
			b = 8'(xs());
			exp_tx.push_back(b);
			line_byte(b);
		end
		wait_cnt(n_eop, k);
	endtask : tx_pkt
	task automatic rx_pkt(input int n, input logic fwd);
		int w;
		for (int i = 0; i < n; i++) begin
			if (fwd && i >= 4) exp_pay.push_back(pk[i]);
			rx_valid_i = 1'b1;
			rx_sop_i = (i == 0);
			rx_eop_i = (i == n - 1);
			rx_data_i = pk[i];
			w = 0;
			do begin
				@(posedge core_clk_i);
				w++;
			end while (rx_ready_o !== 1'b1 && w < 100);
			if (w >= 100) check(rx_ready_o, 1);
			#2;
		end
		rx_valid_i = 1'b0;
		rx_sop_i = 1'b0;
		rx_eop_i = 1'b0;
	endtask : rx_pkt
	task automatic drain();
		for (int i = 0; i < 300 && exp_pay.size() > 0; i++) step(1);
		check(exp_pay.size(), 0);
	endtask : drain
	always @(posedge core_clk_i) begin
		if (got === 1'b1 && !skip_tx)
			check(tx_data_o, exp_tx.size() ? exp_tx.pop_front() : 8'hxx);
		if (pay_valid_o === 1'b1)
			check(pay_data_o, exp_pay.size() ? exp_pay.pop_front() : 8'hxx);
		if (got_eop === 1'b1) n_eop++;
		if (rx_done_o === 1'b1 || rx_ach_o === 1'b1) n_end++;
		if (rx_malformed_o === 1'b1) n_mal++;
		if (rx_ach_o === 1'b1) n_ach++;
	end
	initial begin
		core_clk_i = 1'b0;
		forever #25 core_clk_i = ~core_clk_i;
	end
	initial begin
		#1000000;
		num_errors++;
		finish_test();
	end
	initial begin
		{rst_i, tx_en_i, ac_fault_i, loss_state_i, line_bit_i, line_strobe_i} = 6'h20;
		{rx_valid_i, rx_sop_i, rx_eop_i, fill_req_i, hold, skip_tx, rx_data_i} = 14'h0;
		{num_errors, n_compared, n_eop, n_end, n_mal, n_ach} = '0;
		xs_ff = 32'h18;
		cfg = '0;
		cfg.pay_size = 11'(PS);
		cfg.len_en = 1'b1;
		seed = 16'hffff; // second packet wraps the sequence
		step(5);
		rst_i = 1'b0;
		step(2);
		for (int k = 0; k < 3; k++) tx_pkt(k == 1, k == 0, 16'(seed + k));
		check(tx_ovf_o, 0);
		for (int k = 0; k < 6; k++) begin
			pk[0] = tb0[k];
			pk[1] = tb1[k];
			pk[2] = 8'h0;
			pk[3] = 8'(k);
			for (int i = 4; i < 32; i++) pk[i] = 8'(xs());
			if (k == 4) repeat (PS) exp_pay.push_back(pw_pkg::FILL_BYTE);
			rx_pkt(tn[k], tb0[k][7:3] == 5'h0);
			wait_cnt(n_end, k + 1);
			check(n_mal, tm[k]);
			if (k < 5) check(rx_seq_o, k);
			if (k < 5) check(rx_lflag_o, k == 4);
		end
		check(n_ach, 1);
		drain();
		repeat (PS) exp_pay.push_back(pw_pkg::FILL_BYTE);
		fill_req_i = 1'b1;
		step(1);
		fill_req_i = 1'b0;
		drain();
		skip_tx = 1'b1;
		hold = 1'b1;
		tx_en_i = 1'b1;
		step(1);
		tx_en_i = 1'b0;
		repeat (PS + 4) line_byte(8'(xs()));
		check(tx_ovf_o, 1);
		hold = 1'b0;
		wait_cnt(n_eop, 4);
		finish_test();
	end
endmodule : tdm_pseudowire_packetizer_tb
